// file: shared/ccos_params.svh
// constants of the clock output configuration block
`ifndef CCOS_PARAMS_SVH
`define CCOS_PARAMS_SVH
`define CCOS_ADDR_HI 5'h1b
`define CCOS_CMD_FLAG 7
`define CCOS_IDX_PLL 7'h00
`define CCOS_IDX_TEST 7'h01
`define CCOS_IDX_ID 7'h02
`define CCOS_PLL_RST 8'h1f
`define CCOS_TEST_RST 8'h00
`define CCOS_FACT_MSB 6
`define CCOS_FACT_LSB 4
`define CCOS_OE_MSB 3
`define CCOS_TEST_BIT 0
`define CCOS_BITS_PER_BYTE 4'h8
`endif

// file: shared/ccos_pkg.sv
// types of the clock output configuration block
package ccos_pkg;
    // serial slave states, gray along the usual path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_CMD = 4'h2,
        ST_CMD_ACK = 4'h6,
        ST_WDAT = 4'h7,
        ST_WDAT_ACK = 4'h5,
        ST_RDAT = 4'h4,
        ST_RDAT_ACK = 4'hc,
        ST_SKIP = 4'hd
    } ccos_state_t;
endpackage

// file: logic/ccos_top.sv
// serial configuration slave and output selection of the four-output clock generator
`timescale 1ns/1ns
`include "ccos_params.svh"
module ccos_top
    import ccos_pkg::*;
#(
    parameter logic [4:0] REV_CODE = 5'h05, // arbitrary value
    parameter logic [2:0] VENDOR_CODE = 3'h2 // arbitrary value
) (
    // clocks and reset
    input wire logic ref_clk_i,
    input wire logic pll_clk_i,
    input wire logic resetn_i,
    // serial pins, sda open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // control pins
    input wire logic slave_sel_pin_zero_i,
    input wire logic slave_sel_pin_one_i,
    input wire logic out_enable_i,
    input wire logic bypass_n_i,
    // pll control
    output logic pll_run_o,
    output logic [2:0] pll_factor_sel_o,
    output logic [3:0] mult_num_o,
    output logic [2:0] mult_den_o,
    // clock outputs, oe low while driven
    output logic [3:0] clk_out_o,
    output logic [3:0] clk_out_n_o,
    output logic [3:0] clk_oe_n_o
);

    // multiplier as numerator and denominator
    function automatic logic [6:0] mult_decode(input logic [2:0] sel);
        logic [6:0] r;
        r = 7'h00;
        case (sel)
            3'h0: r = {4'h3, 3'h1};
            3'h1: r = {4'h4, 3'h1};
            3'h2: r = {4'h5, 3'h1};
            3'h3: r = {4'h6, 3'h1};
            3'h4: r = {4'h8, 3'h1};
            3'h5: r = {4'h9, 3'h2};
            3'h6: r = {4'hf, 3'h2};
            default: r = {4'hf, 3'h4};
        endcase
        return r;
    endfunction

    // pin synchronisers
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic scl_d;
    logic sda_d;
    logic scl_s;
    logic sda_s;
    logic [1:0] id_s;
    logic en_s;
    logic byp_n_s;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1 <= 6'h3f;
            sync2 <= 6'h3f;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {scl_i, sda_i, slave_sel_pin_one_i, slave_sel_pin_zero_i,
                      out_enable_i, bypass_n_i};
            sync2 <= sync1;
            scl_d <= sync2[5];
            sda_d <= sync2[4];
        end
    end

    assign scl_s = sync2[5];
    assign sda_s = sync2[4];
    assign id_s = sync2[3:2];
    assign en_s = sync2[1];
    assign byp_n_s = sync2[0];

    // bus events
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;

    // slave state and registers
    ccos_state_t state;
    ccos_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [6:0] idx;
    logic [6:0] next_idx;
    logic rd_mode;
    logic next_rd_mode;
    logic drive_low;
    logic next_drive_low;
    logic [7:0] pll_reg;
    logic [7:0] next_pll_reg;
    logic [7:0] test_reg;
    logic [7:0] next_test_reg;
    logic [7:0] rd_byte;
    logic addr_hit;

    // read-only identity byte
    logic [7:0] id_byte;
    assign id_byte = {REV_CODE, VENDOR_CODE};

    // read mux over the three bytes
    always_comb begin
        case (idx)
            `CCOS_IDX_PLL: rd_byte = pll_reg;
            `CCOS_IDX_TEST: rd_byte = test_reg;
            `CCOS_IDX_ID: rd_byte = id_byte;
            default: rd_byte = 8'h00;
        endcase
    end

    // address compare against strapped id
    assign addr_hit = (shreg[7:1] == {`CCOS_ADDR_HI, id_s});

    // serial slave next values
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_idx = idx;
        next_rd_mode = rd_mode;
        next_drive_low = drive_low;
        next_pll_reg = pll_reg;
        next_test_reg = test_reg;
        if (start_ev) begin
            // start or repeated start
            next_state = ST_ADDR;
            next_cnt = 4'h0;
            next_drive_low = 1'b0;
        end else if (stop_ev) begin
            next_state = ST_IDLE;
            next_drive_low = 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_CMD, ST_WDAT: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == `CCOS_BITS_PER_BYTE) begin
                        next_cnt = 4'h0;
                        next_drive_low = 1'b1;
                        if (state == ST_ADDR) begin
                            next_rd_mode = shreg[0];
                            next_state = ST_ADDR_ACK;
                            if (!addr_hit) begin
                                next_drive_low = 1'b0;
                                next_state = ST_SKIP;
                            end
                        end else if (state == ST_CMD) begin
                            next_idx = shreg[`CCOS_CMD_FLAG] ? shreg[6:0] : 7'h7f;
                            next_state = ST_CMD_ACK;
                        end else begin
                            // write the addressed byte
                            if (idx == `CCOS_IDX_PLL) begin
                                next_pll_reg = shreg;
                            end
                            if (idx == `CCOS_IDX_TEST) begin
                                next_test_reg = shreg;
                            end
                            next_state = ST_WDAT_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rd_mode) begin
                            // first data bit out on this fall
                            next_shreg = rd_byte;
                            next_drive_low = ~rd_byte[7];
                            next_state = ST_RDAT;
                        end else begin
                            next_drive_low = 1'b0;
                            next_state = ST_CMD;
                        end
                    end
                end
                ST_CMD_ACK: begin
                    if (scl_fall) begin
                        next_drive_low = 1'b0;
                        next_state = ST_WDAT;
                    end
                end
                ST_WDAT_ACK: begin
                    if (scl_fall) begin
                        // further bytes go to the next index
                        next_drive_low = 1'b0;
                        next_idx = idx + 7'h01;
                        next_state = ST_WDAT;
                    end
                end
                ST_RDAT: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == `CCOS_BITS_PER_BYTE) begin
                            next_cnt = 4'h0;
                            next_drive_low = 1'b0;
                            next_state = ST_RDAT_ACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_drive_low = ~shreg[6];
                        end
                    end
                end
                ST_RDAT_ACK: begin
                    // host ack continues, nack waits for stop
                    if (scl_rise) begin
                        next_rd_mode = ~sda_s;
                        if (!sda_s) begin
                            // step the index early so the next byte is ready at the fall
                            next_idx = idx + 7'h01;
                        end
                    end else if (scl_fall) begin
                        if (rd_mode) begin
                            // next msb out on the fall that ends the host ack
                            next_shreg = rd_byte;
                            next_drive_low = ~rd_byte[7];
                            next_state = ST_RDAT;
                        end else begin
                            next_state = ST_SKIP;
                        end
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    next_drive_low = 1'b0;
                end
                default: begin
                    next_state = ST_IDLE;
                    next_drive_low = 1'b0;
                end
            endcase
        end
    end

    // serial slave registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            idx <= 7'h00;
            rd_mode <= 1'b0;
            drive_low <= 1'b0;
            pll_reg <= `CCOS_PLL_RST;
            test_reg <= `CCOS_TEST_RST;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            idx <= next_idx;
            rd_mode <= next_rd_mode;
            drive_low <= next_drive_low;
            pll_reg <= next_pll_reg;
            test_reg <= next_test_reg;
        end
    end

    // open-drain data pin
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~drive_low;

    // output selection next values
    logic test_on;
    logic [3:0] out_bits;
    logic [3:0] pll_mask;
    logic [3:0] next_pll_mask;
    logic [3:0] oe_n;
    logic [3:0] next_oe_n;
    logic ref_sel;
    logic next_ref_sel;
    logic pll_run;
    logic next_pll_run;
    logic [2:0] fact;
    logic [2:0] next_fact;
    logic [6:0] mult;
    logic [6:0] next_mult;

    assign test_on = test_reg[`CCOS_TEST_BIT];
    assign out_bits = {pll_reg[0], pll_reg[1], pll_reg[2], pll_reg[`CCOS_OE_MSB]};

    always_comb begin
        next_fact = pll_reg[`CCOS_FACT_MSB:`CCOS_FACT_LSB];
        next_mult = mult_decode(next_fact);
        next_pll_run = byp_n_s;
        next_ref_sel = ~byp_n_s;
        next_pll_mask = 4'h0;
        next_oe_n = 4'hf;
        if (!en_s) begin
            next_oe_n = 4'hf;
        end else if (test_on) begin
            next_oe_n = 4'hf;
        end else if (!byp_n_s) begin
            next_oe_n = 4'h0;
        end else begin
            next_pll_mask = out_bits;
            next_oe_n = ~out_bits;
        end
    end

    // output selection registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fact <= 3'h0;
            mult <= 7'h00;
            pll_run <= 1'b0;
            ref_sel <= 1'b0;
            pll_mask <= 4'h0;
            oe_n <= 4'hf;
        end else begin
            fact <= next_fact;
            mult <= next_mult;
            pll_run <= next_pll_run;
            ref_sel <= next_ref_sel;
            pll_mask <= next_pll_mask;
            oe_n <= next_oe_n;
        end
    end

    // pll-side gates, mask crossed by two flops
    logic [3:0] gate_s1;
    logic [3:0] gate_s2;

    always_ff @(posedge pll_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gate_s1 <= 4'h0;
            gate_s2 <= 4'h0;
        end else begin
            gate_s1 <= pll_mask;
            gate_s2 <= gate_s1;
        end
    end

    // clock outputs
    assign pll_run_o = pll_run;
    assign pll_factor_sel_o = fact;
    assign mult_num_o = mult[6:3];
    assign mult_den_o = mult[2:0];
    assign clk_out_o = ref_sel ? {4{ref_clk_i}} : ({4{pll_clk_i}} & gate_s2);
    assign clk_out_n_o = ~clk_out_o;
    assign clk_oe_n_o = oe_n;

endmodule

// file: dv/ccos_chk.sv
// port assertions of the clock output configuration block
`timescale 1ns/1ns
module ccos_chk (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // pins watched
    input wire logic scl_i,
    input wire logic sda_oe_n_o,
    input wire logic out_enable_i,
    input wire logic bypass_n_i,
    input wire logic pll_run_o,
    input wire logic [2:0] pll_factor_sel_o,
    input wire logic [3:0] mult_num_o,
    input wire logic [2:0] mult_den_o,
    input wire logic [3:0] clk_out_o,
    input wire logic [3:0] clk_out_n_o,
    input wire logic [3:0] clk_oe_n_o
);
    localparam logic [6:0] TBL [8] = '{7'h19, 7'h21, 7'h29, 7'h31, 7'h41, 7'h4a, 7'h7a, 7'h7c};
    logic [2:0] up;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // cycles since reset release, saturating
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            up <= 3'h0;
        end else if (up != 3'h7) begin
            up <= up + 3'h1;
        end
    end
    // pin levels held long enough to pass the syncs
    sequence s_off;
        (!out_enable_i)[*5];
    endsequence
    sequence s_byp;
        (out_enable_i && !bypass_n_i)[*6];
    endsequence
    a_disable_hiz: assert property (s_off |-> clk_oe_n_o == 4'hf) else $error("outputs driven while disabled");
    a_bypass_pll_off: assert property ((!bypass_n_i)[*5] |-> !pll_run_o) else $error("pll runs in bypass");
    a_pll_run_on: assert property (bypass_n_i[*5] |-> pll_run_o) else $error("pll stopped outside bypass");
    a_bypass_all_same: assert property (s_byp |-> clk_oe_n_o == 4'h0 || clk_oe_n_o == 4'hf)
        else $error("bypass mix");
    a_factor_decode: assert property (up == 3'h7 && $stable(pll_factor_sel_o) |->
        {mult_num_o, mult_den_o} == TBL[pll_factor_sel_o]) else $error("factor decode wrong");
    a_reset_load: assert property (up == 3'h5 |-> pll_factor_sel_o == 3'h1 && mult_num_o == 4'h4
        && mult_den_o == 3'h1) else $error("power-up factor wrong");
    a_sda_low_phase: assert property ($changed(sda_oe_n_o) |-> !scl_i) else $error("sda moved with scl high");
    a_diff_pair: assert property (clk_out_n_o == ~clk_out_o) else $error("outputs not complementary");
endmodule
bind ccos_top ccos_chk u_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o),
    .out_enable_i(out_enable_i), .bypass_n_i(bypass_n_i), .pll_run_o(pll_run_o), .pll_factor_sel_o(pll_factor_sel_o),
    .mult_num_o(mult_num_o), .mult_den_o(mult_den_o), .clk_out_o(clk_out_o), .clk_out_n_o(clk_out_n_o),
    .clk_oe_n_o(clk_oe_n_o));

// file: dv/ccos_host.sv
// serial host model driving scl and pulling sda
`timescale 1ns/1ns
module ccos_host (
    // clock
    input wire logic clk_i,
    // bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o,
    // transaction result {all acked, read byte}
    output logic [8:0] res_o,
    output logic res_stb_o
);
    logic r;
    // bus idle at time zero
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        res_o = 9'h000;
        res_stb_o = 1'b0;
    end
    // one third of a bit, well above the sync delay
    task automatic w();
        repeat (10) @(negedge clk_i);
    endtask
    // one bit slot, sda changes only while scl low
    task automatic bt(input logic b);
        w();
        sda_low_o = !b;
        w();
        scl_o = 1'b1;
        w();
        r = sda_i;
        scl_o = 1'b0;
    endtask
    // start or repeated start
    task automatic st();
        w();
        sda_low_o = 1'b0;
        w();
        scl_o = 1'b1;
        w();
        sda_low_o = 1'b1;
        w();
        scl_o = 1'b0;
    endtask
    // stop, bus left idle
    task automatic sp();
        w();
        sda_low_o = 1'b1;
        w();
        scl_o = 1'b1;
        w();
        sda_low_o = 1'b0;
        w();
    endtask
    // byte out msb first, ack slot released
    task automatic tx(input logic [7:0] d, inout logic ok);
        for (int i = 7; i >= 0; i--) bt(d[i]);
        bt(1'b1);
        ok = ok & !r;
    endtask
    // hand a result to the bench
    task automatic pub(input logic ok, input logic [7:0] d);
        res_o = {ok, d};
        res_stb_o = 1'b1;
        @(negedge clk_i);
        res_stb_o = 1'b0;
    endtask
    // byte write: address, command, data
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
        logic ok;
        ok = 1'b1;
        st();
        tx({a, 1'b0}, ok);
        tx(c, ok);
        tx(d, ok);
        sp();
        pub(ok, 8'h00);
    endtask
    // byte read: command, repeated start, one byte, nack, stop
    task automatic rd(input logic [6:0] a, input logic [7:0] c);
        logic ok;
        logic [7:0] d;
        ok = 1'b1;
        st();
        tx({a, 1'b0}, ok);
        tx(c, ok);
        st();
        tx({a, 1'b1}, ok);
        for (int i = 0; i < 8; i++) begin
            bt(1'b1);
            d = {d[6:0], r};
        end
        bt(1'b1);
        sp();
        pub(ok, d);
    endtask
endmodule

// file: dv/tb.sv
// self-checking bench of the clock output configuration block
`timescale 1ns/1ns
module tb;
    localparam logic [4:0] REV = 5'h0a; // arbitrary value
    localparam logic [2:0] VEN = 3'h5; // arbitrary value
    localparam logic [6:0] TBL [8] = '{7'h19, 7'h21, 7'h29, 7'h31, 7'h41, 7'h4a, 7'h7a, 7'h7c};
    logic clk = 1'b0, pclk = 1'b0, rst_n = 1'b0, en = 1'b1, byp_n = 1'b1, id0 = 1'b0, id1 = 1'b0;
    logic scl, sda, sda_low, sda_o, sda_oe_n, run, stb;
    logic [2:0] fsel, den;
    logic [3:0] num, co, con, coe;
    logic [8:0] res;
    logic [7:0] d, b0;
    logic [6:0] ad;
    logic [8:0] q[$];
    int n_errors = 0, checks = 0, seed = 32'hab95;
    // clocks, pll clock offset in phase
    always #4 clk = ~clk;
    initial begin
        #3;
        forever #6 pclk = ~pclk;
    end
    // sda pulled up, low when either side pulls
    assign sda = (sda_oe_n ? 1'b1 : sda_o) & !sda_low;
    ccos_top #(.REV_CODE(REV), .VENDOR_CODE(VEN)) u_dut (.ref_clk_i(clk), .pll_clk_i(pclk), .resetn_i(rst_n),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .slave_sel_pin_zero_i(id0),
        .slave_sel_pin_one_i(id1), .out_enable_i(en), .bypass_n_i(byp_n), .pll_run_o(run),
        .pll_factor_sel_o(fsel), .mult_num_o(num), .mult_den_o(den), .clk_out_o(co), .clk_out_n_o(con),
        .clk_oe_n_o(coe));
    ccos_host u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low), .res_o(res), .res_stb_o(stb));
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmp_ser(input logic [8:0] e, input logic [8:0] g);
        checks++;
        if (e !== g) begin
            n_errors++;
            $display("unexpected serial result exp %h got %h", e, g);
        end
    endtask
    task automatic cmp_pin(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (e !== g) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // serial transfers noting the expected result
    task automatic w_(input logic [7:0] c, input logic [7:0] v);
        q.push_back({1'b1, 8'h00});
        u_host.wr(ad, c, v);
    endtask
    task automatic r_(input logic [7:0] c, input logic [7:0] v);
        q.push_back({1'b1, v});
        u_host.rd(ad, c);
    endtask
    task automatic settle();
        repeat (10) @(negedge clk);
    endtask
    // oldest note against each result
    always @(posedge stb) cmp_ser(q.pop_front(), res);
    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        settle();
        ad = {5'h1b, id1, id0};
        r_(8'h80, 8'h1f);
        r_(8'h81, 8'h00);
        cmp_pin("oe", 8'h00, {4'h0, coe});
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            d = 8'($random(seed));
            d[6:4] = 3'(k);
            // outputs parked off for factor codes 4 and 6
            if (k == 4 || k == 6) begin
                d[3:0] = 4'h0;
            end
            w_(8'h80, d);
            r_(8'h80, d);
            settle();
            cmp_pin("factor", 8'(k), {5'h00, fsel});
            cmp_pin("mult", {1'b0, TBL[k]}, {1'b0, num, den});
            cmp_pin("oe", {4'h0, ~d[0], ~d[1], ~d[2], ~d[3]}, {4'h0, coe});
            // pll clock high, so each output shows its own gate
            @(posedge pclk);
            #1;
            cmp_pin("clk", {4'h0, d[0], d[1], d[2], d[3]}, {4'h0, co});
            @(negedge clk);
        end
        b0 = d;
        $display("test factors done");
        byp_n = 1'b0;
        settle();
        cmp_pin("oe", 8'h00, {4'h0, coe});
        cmp_pin("run", 8'h00, {7'h00, run});
        // reference clock high, every output follows it
        @(posedge clk);
        #1;
        cmp_pin("clk", 8'h0f, {4'h0, co});
        @(negedge clk);
        en = 1'b0;
        settle();
        cmp_pin("oe", 8'h0f, {4'h0, coe});
        byp_n = 1'b1;
        settle();
        cmp_pin("oe", 8'h0f, {4'h0, coe});
        cmp_pin("run", 8'h01, {7'h00, run});
        en = 1'b1;
        $display("test modes done");
        d = 8'($random(seed)) | 8'h01;
        w_(8'h81, d);
        r_(8'h81, d);
        settle();
        cmp_pin("oe", 8'h0f, {4'h0, coe});
        w_(8'h81, 8'h00);
        settle();
        cmp_pin("oe", {4'h0, ~b0[0], ~b0[1], ~b0[2], ~b0[3]}, {4'h0, coe});
        w_(8'h82, 8'h00);
        r_(8'h82, {REV, VEN});
        r_(8'h02, 8'h00);
        $display("test vendor done");
        {id1, id0} = 2'($random(seed));
        settle();
        ad = {5'h1b, id1, id0};
        r_(8'h80, b0);
        for (int k = 0; k < 2; k++) begin
            q.push_back(9'h000);
            u_host.wr(ad ^ (k ? 7'h10 : 7'h01), 8'h80, 8'h00);
        end
        r_(8'h80, b0);
        $display("test address done");
        finish_test();
    end
endmodule
